/* File: hw/pae_defs.vh */
// Constants shared by the process alarm evaluator.
`ifndef PAE_DEFS_VH
`define PAE_DEFS_VH
// Alarm type codes.
`define PAE_T_OFF       5'd0
`define PAE_T_ULDEV     5'd1
`define PAE_T_UPDEV     5'd2
`define PAE_T_LODEV     5'd3
`define PAE_T_RANGE     5'd4
`define PAE_T_ULDEV_SB  5'd5
`define PAE_T_UPDEV_SB  5'd6
`define PAE_T_LODEV_SB  5'd7
`define PAE_T_ABSUP     5'd8
`define PAE_T_ABSLO     5'd9
`define PAE_T_ABSUP_SB  5'd10
`define PAE_T_ABSLO_SB  5'd11
`define PAE_T_LOOP      5'd12
`define PAE_T_RATE      5'd13
`define PAE_T_SPUP      5'd14
`define PAE_T_SPLO      5'd15
`define PAE_T_MVUP      5'd16
`define PAE_T_MVLO      5'd17
`define PAE_T_RSPUP     5'd18
`define PAE_T_RSPLO     5'd19
`define PAE_T_MAX       5'd19
`define PAE_T_RESET     5'd2
// Register byte offsets.
`define PAE_OFF_TYPE    12'h000
`define PAE_OFF_ALMX    12'h004
`define PAE_OFF_ALMH    12'h008
`define PAE_OFF_ALML    12'h00C
`define PAE_OFF_ONDLY   12'h010
`define PAE_OFF_OFFDLY  12'h014
`define PAE_OFF_CTRL    12'h018
`define PAE_OFF_STAT    12'h01C
// Control register fields.
`define PAE_CTRL_ASSIGN 0
`define PAE_CTRL_HEATCOOL 1
`define PAE_CTRL_RESTART 2
// Timing.
`define PAE_DLY_MAX_S   10'd999
`define PAE_CLK_HZ      100000000
`endif

/* File: hw/pae_alarm.v */
// Single-channel process alarm evaluator with APB register access.
`default_nettype none
`include "pae_defs.vh"
// What this block does
// - Type selector, nineteen behaviours, reset two, zero off.
// - Separate ON and OFF delays, 0 to 999 s.
// - Heater channel shows heater alarm until assigned.
// - Type 1: alarm outside deviation band.
// - Type 2: value above set point by deviation.
// - Type 3: value below set point by deviation.
// - Type 4: alarm inside deviation band.
// - Types 1, 4, 5 use upper and lower limits.
// - Types 5,6,7,10,11 add standby sequence.
// - Type 5 off when hysteresis regions overlap.
// - Type 8: value above alarm value.
// - Type 9: value below alarm value.
// - Loop burnout type only on channel one.
// - Type 13 uses external change-rate detector.
// - Type 14: set point above alarm value.
// - Type 15: set point below alarm value.
// - Types 16, 17: manipulated variable compares.
// - Heat-cool: upper uses heat, lower cool.
// - Types 18, 19: remote set point compares.
// - Remote types need fitted remote input.
module pae_alarm #(
    parameter                CHANNEL       = 1,
    parameter                HEATER_FITTED = 1,
    parameter                RSP_FITTED    = 1,
    parameter                DW            = 16,
    parameter [31:0]         TICK_CYCLES   = `PAE_CLK_HZ
)
(
    // APB slave
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    // Loop values, signed, same clock domain
    input  wire [DW-1:0]     process_value,
    input  wire [DW-1:0]     set_point,
    input  wire [DW-1:0]     manipulated_variable,
    input  wire [DW-1:0]     manipulated_variable_cool,
    input  wire [DW-1:0]     remote_set_point,
    input  wire [DW-1:0]     hysteresis,
    input  wire              set_point_changed,
    input  wire              loop_burnout_alarm,
    input  wire              change_rate_alarm,
    input  wire              heater_fault_alarm,
    // Alarm output
    output reg               alarm_out
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function gt;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            gt = $signed(a) > $signed(b);
        end
    endfunction

    function legal_type;
        input [4:0] t;
        begin
            legal_type = (t <= `PAE_T_MAX)
                && !(t == `PAE_T_LOOP && CHANNEL != 1)
                && !((t == `PAE_T_RSPUP || t == `PAE_T_RSPLO) && RSP_FITTED == 0);
        end
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    reg  [4:0]    type_q;
    reg  [DW-1:0] almx_q;
    reg  [DW-1:0] almh_q;
    reg  [DW-1:0] alml_q;
    reg  [9:0]    on_dly_q;
    reg  [9:0]    off_dly_q;
    reg           assign_q;
    reg           heatcool_q;
    reg           standby_q;
    reg           tick_q;
    reg  [9:0]    sec_cnt_q;
    reg  [31:0]   tick_cnt_q;
    wire          wr_en = psel & penable & pwrite;
    wire          tick  = (tick_cnt_q == TICK_CYCLES - 32'h0000_0001);
    wire          dec_hit;
    wire          heater_mode = (HEATER_FITTED != 0) && (CHANNEL == 1) && !assign_q;

    assign pready  = 1'b1;
    assign dec_hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~dec_hit;

    function [9:0] clamp_dly;
        input [31:0] v;
        begin
            clamp_dly = (v[31:10] != 22'h00_0000 || v[9:0] > `PAE_DLY_MAX_S) ?
                        `PAE_DLY_MAX_S : v[9:0];
        end
    endfunction

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_q     <= `PAE_T_RESET;
            almx_q     <= {DW{1'b0}};
            almh_q     <= {DW{1'b0}};
            alml_q     <= {DW{1'b0}};
            on_dly_q   <= 10'h000;
            off_dly_q  <= 10'h000;
            assign_q   <= 1'b0;
            heatcool_q <= 1'b0;
        end
        else if (wr_en && dec_hit)
        begin
            case (paddr)
                `PAE_OFF_TYPE:
                begin
                    if (legal_type(pwdata[4:0]) && pwdata[31:5] == 27'h000_0000)
                        type_q <= pwdata[4:0];
                end
                `PAE_OFF_ALMX:   almx_q    <= pwdata[DW-1:0];
                `PAE_OFF_ALMH:   almh_q    <= pwdata[DW-1:0];
                `PAE_OFF_ALML:   alml_q    <= pwdata[DW-1:0];
                `PAE_OFF_ONDLY:  on_dly_q  <= clamp_dly(pwdata);
                `PAE_OFF_OFFDLY: off_dly_q <= clamp_dly(pwdata);
                `PAE_OFF_CTRL:
                begin
                    assign_q   <= pwdata[`PAE_CTRL_ASSIGN];
                    heatcool_q <= pwdata[`PAE_CTRL_HEATCOOL];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Condition evaluation
    // ==========================================================
    wire [DW-1:0] up_lim  = set_point + almh_q;
    wire [DW-1:0] lo_lim  = set_point - alml_q;
    wire [DW-1:0] dev_up  = set_point + almx_q;
    wire [DW-1:0] dev_lo  = set_point - almx_q;
    wire          above_h = !gt(up_lim, process_value);
    wire          below_l = !gt(process_value, lo_lim);
    wire          overlap = !gt(up_lim - hysteresis, lo_lim + hysteresis);
    wire [DW-1:0] mv_up   = manipulated_variable;
    wire [DW-1:0] mv_lo   = heatcool_q ? manipulated_variable_cool : manipulated_variable;
    reg           cond;
    reg           uses_standby;

    always @*
    begin
        cond = 1'b0;
        uses_standby = 1'b0;
        case (type_q)
            `PAE_T_ULDEV:    cond = above_h | below_l;
            `PAE_T_ULDEV_SB:
            begin
                cond = (above_h | below_l) & ~overlap;
                uses_standby = 1'b1;
            end
            `PAE_T_UPDEV:    cond = !gt(dev_up, process_value);
            `PAE_T_UPDEV_SB:
            begin
                cond = !gt(dev_up, process_value);
                uses_standby = 1'b1;
            end
            `PAE_T_LODEV:    cond = !gt(process_value, dev_lo);
            `PAE_T_LODEV_SB:
            begin
                cond = !gt(process_value, dev_lo);
                uses_standby = 1'b1;
            end
            `PAE_T_RANGE:    cond = !gt(process_value, up_lim) & !gt(lo_lim, process_value);
            `PAE_T_ABSUP:    cond = gt(process_value, almx_q);
            `PAE_T_ABSUP_SB:
            begin
                cond = gt(process_value, almx_q);
                uses_standby = 1'b1;
            end
            `PAE_T_ABSLO:    cond = gt(almx_q, process_value);
            `PAE_T_ABSLO_SB:
            begin
                cond = gt(almx_q, process_value);
                uses_standby = 1'b1;
            end
            `PAE_T_LOOP:     cond = loop_burnout_alarm;
            `PAE_T_RATE:     cond = change_rate_alarm;
            `PAE_T_SPUP:     cond = gt(set_point, almx_q);
            `PAE_T_SPLO:     cond = gt(almx_q, set_point);
            `PAE_T_MVUP:     cond = gt(mv_up, almx_q);
            `PAE_T_MVLO:     cond = gt(almx_q, mv_lo);
            `PAE_T_RSPUP:    cond = gt(remote_set_point, almx_q);
            `PAE_T_RSPLO:    cond = gt(almx_q, remote_set_point);
            default:         cond = 1'b0;
        endcase
        if (heater_mode)
        begin
            cond = heater_fault_alarm;
            uses_standby = 1'b0;
        end
    end

    // ==========================================================
    // Standby sequence
    // ==========================================================
    // Armed after reset, a set point change or a type write; released once the
    // condition is seen clear.
    wire type_wr = wr_en && paddr == `PAE_OFF_TYPE;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            standby_q <= 1'b1;
        else if (set_point_changed || type_wr)
            standby_q <= 1'b1;
        else if (!cond)
            standby_q <= 1'b0;
    end

    wire eff = cond & ~(uses_standby & standby_q);

    // ==========================================================
    // Delay timers
    // ==========================================================
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_q <= 32'h0000_0000;
        else if (tick)
            tick_cnt_q <= 32'h0000_0000;
        else
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end

    // The one-second enable leaves a flip-flop as a clean one-cycle pulse.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_q <= 1'b0;
        else
            tick_q <= tick;
    end

    // ==========================================================
    // Output delay state machine
    // ==========================================================
    // A change waits in a pending state; eff going back to the output's
    // present level drops it before its delay has run out.
    localparam [3:0] ST_OFF  = 4'b0001;
    localparam [3:0] ST_ONP  = 4'b0010;
    localparam [3:0] ST_ON   = 4'b0100;
    localparam [3:0] ST_OFFP = 4'b1000;

    reg  [3:0]    state_q;
    reg  [3:0]    state_d;
    reg  [9:0]    sec_cnt_d;
    reg           alarm_d;

    always @*
    begin
        state_d   = state_q;
        sec_cnt_d = sec_cnt_q;
        alarm_d   = alarm_out;
        case (state_q)
            ST_OFF:
            begin
                sec_cnt_d = 10'h000;
                if (eff)
                    state_d = ST_ONP;
            end
            ST_ONP:
            begin
                if (!eff)
                begin
                    state_d   = ST_OFF;
                    sec_cnt_d = 10'h000;
                end
                else if (on_dly_q <= sec_cnt_q)
                begin
                    state_d   = ST_ON;
                    alarm_d   = 1'b1;
                    sec_cnt_d = 10'h000;
                end
                else if (tick_q)
                    sec_cnt_d = sec_cnt_q + 10'h001;
            end
            ST_ON:
            begin
                sec_cnt_d = 10'h000;
                if (!eff)
                    state_d = ST_OFFP;
            end
            ST_OFFP:
            begin
                if (eff)
                begin
                    state_d   = ST_ON;
                    sec_cnt_d = 10'h000;
                end
                else if (off_dly_q <= sec_cnt_q)
                begin
                    state_d   = ST_OFF;
                    alarm_d   = 1'b0;
                    sec_cnt_d = 10'h000;
                end
                else if (tick_q)
                    sec_cnt_d = sec_cnt_q + 10'h001;
            end
            default:
            begin
                state_d   = ST_OFF;
                alarm_d   = 1'b0;
                sec_cnt_d = 10'h000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q   <= ST_OFF;
            sec_cnt_q <= 10'h000;
            alarm_out <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            sec_cnt_q <= sec_cnt_d;
            alarm_out <= alarm_d;
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    reg  [31:0]   prdata_d;

    always @*
    begin
        prdata_d = 32'h0000_0000;
        case (paddr)
            `PAE_OFF_TYPE:   prdata_d[4:0]    = heater_mode ? 5'h00 : type_q;
            `PAE_OFF_ALMX:   prdata_d[DW-1:0] = almx_q;
            `PAE_OFF_ALMH:   prdata_d[DW-1:0] = almh_q;
            `PAE_OFF_ALML:   prdata_d[DW-1:0] = alml_q;
            `PAE_OFF_ONDLY:  prdata_d[9:0]    = on_dly_q;
            `PAE_OFF_OFFDLY: prdata_d[9:0]    = off_dly_q;
            `PAE_OFF_CTRL:
            begin
                prdata_d[`PAE_CTRL_ASSIGN]   = assign_q;
                prdata_d[`PAE_CTRL_HEATCOOL] = heatcool_q;
            end
            `PAE_OFF_STAT:   prdata_d[3:0]    = {heater_mode, standby_q, eff, alarm_out};
            default:         prdata_d = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup phase and held through the access
    // phase, so the bus always sees a registered value.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= prdata_d;
    end

endmodule
`default_nettype wire

/* File: verif/pae_alarm_assertions.sv */
// Concurrent checks on the alarm output of the process alarm evaluator.
`default_nettype none
// ====================
// Checker
module pae_alarm_chk #(parameter DW = 16) (
    // Clock, reset and register writes
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    // Loop values and output
    input wire logic [DW-1:0] process_value,
    input wire logic [DW-1:0] set_point,
    input wire logic [DW-1:0] manipulated_variable,
    input wire logic [DW-1:0] manipulated_variable_cool,
    input wire logic [DW-1:0] remote_set_point,
    input wire logic [DW-1:0] hysteresis,
    input wire logic          set_point_changed,
    input wire logic          loop_burnout_alarm,
    input wire logic          change_rate_alarm,
    input wire logic          heater_fault_alarm,
    input wire logic          alarm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]              typ_q;
    logic [DW-1:0]           almx_q;
    logic [2:0]              cnt_q;
    logic [6*DW+3:0]         ins_q;
    logic                    asg_q, hc_q, xk_q, don_q, doff_q;
    wire logic               wr = psel & penable & pwrite;
    wire logic [6*DW+3:0]    ins = {process_value, set_point, manipulated_variable,
        manipulated_variable_cool, remote_set_point, hysteresis, set_point_changed,
        loop_burnout_alarm, change_rate_alarm, heater_fault_alarm};
    wire logic signed [DW:0] proc_s = $signed(process_value);
    wire logic signed [DW:0] setp_s = $signed(set_point);
    wire logic signed [DW:0] alm_s  = $signed(almx_q);
    wire logic signed [DW:0] mv_s   = $signed(manipulated_variable);
    wire logic signed [DW:0] mvc_s  = $signed(manipulated_variable_cool);
    wire logic signed [DW:0] rem_s  = $signed(remote_set_point);
    wire logic signed [DW+1:0] dev_s = proc_s - setp_s;
    // Checks apply only once inputs and settings have been still for three cycles.
    wire logic               ok  = cnt_q >= 3'h3 && ins == ins_q && don_q && doff_q;
    wire logic               okx = ok && asg_q && xk_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            typ_q  <= 5'h2;
            almx_q <= '0;
            cnt_q  <= 3'h0;
            ins_q  <= '0;
            {asg_q, hc_q, xk_q} <= 3'h0;
            {don_q, doff_q} <= 2'h3;
        end
        else
        begin
            ins_q <= ins;
            cnt_q <= (wr || ins != ins_q) ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
            if (wr && paddr == 12'h000 && pwdata <= 32'h0000_0013)
                typ_q <= pwdata[4:0];
            if (wr && paddr == 12'h004)
                {xk_q, almx_q} <= {1'b1, pwdata[DW-1:0]};
            if (wr && paddr == 12'h010)
                don_q <= pwdata == 32'h0000_0000;
            if (wr && paddr == 12'h014)
                doff_q <= pwdata == 32'h0000_0000;
            if (wr && paddr == 12'h018)
                {hc_q, asg_q} <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_type_off: assert property (okx && typ_q == 5'h0 |-> (!alarm_out) [*2])
        else $error("alarm on while type is off");
    chk_heater_follow: assert property (ok && !asg_q |-> alarm_out == heater_fault_alarm)
        else $error("alarm does not follow heater fault");
    chk_dev_upper: assert property (okx && typ_q == 5'h2 |-> alarm_out == (dev_s >= alm_s))
        else $error("upper deviation alarm wrong");
    chk_dev_lower: assert property (okx && typ_q == 5'h3 |-> alarm_out == (-dev_s >= alm_s))
        else $error("lower deviation alarm wrong");
    chk_abs_upper: assert property (okx && typ_q == 5'h8 |-> alarm_out == (proc_s > alm_s))
        else $error("absolute upper alarm wrong");
    chk_abs_lower: assert property (okx && typ_q == 5'h9 |-> alarm_out == (proc_s < alm_s))
        else $error("absolute lower alarm wrong");
    chk_sp_upper: assert property (okx && typ_q == 5'hE |-> alarm_out == (setp_s > alm_s))
        else $error("set point upper alarm wrong");
    chk_mv_lower: assert property (okx && typ_q == 5'h11 |->
        alarm_out == ((hc_q ? mvc_s : mv_s) < alm_s))
        else $error("manipulated lower alarm wrong");
    chk_rsp_upper: assert property (okx && typ_q == 5'h12 |-> alarm_out == (rem_s > alm_s))
        else $error("remote upper alarm wrong");
    cov_heater: cover property (ok && !asg_q && alarm_out);
    cov_abs: cover property (okx && typ_q == 5'h8 && alarm_out);
    cov_rise: cover property ($rose(alarm_out));
endmodule
bind pae_alarm pae_alarm_chk #(.DW(DW)) pae_alarm_chk_i (.*);
`default_nettype wire

/* File: verif/pae_front_end.sv */
// Front end model that presents loop values and fault flags to the evaluator.
`default_nettype none
module pae_front_end #(parameter DW = 16) (
    // Clock
    input  wire logic          pclk,
    // Loop values
    output var  logic [DW-1:0] process_value,
    output var  logic [DW-1:0] set_point,
    output var  logic [DW-1:0] hysteresis,
    output var  logic          flag
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {process_value, set_point, hysteresis, flag} = '0;
    end
    // New values appear just after a rising edge, like a sampled measurement.
    task automatic set(input logic [DW-1:0] p, input logic [DW-1:0] s,
                       input logic [DW-1:0] h, input logic f);
        @(posedge pclk);
        {process_value, set_point, hysteresis, flag} <= {p, s, h, f};
    endtask
endmodule
`default_nettype wire

/* File: verif/process_alarm_evaluator_tb_top.sv */
// Self-checking testbench for the process alarm evaluator.
`default_nettype none
module process_alarm_evaluator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm_out, flag, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] process_value, set_point, hysteresis;
    logic [4:0]  cur;
    int          failures, num_checks;
    wire logic [15:0] manipulated_variable      = 16'h0078;
    wire logic [15:0] manipulated_variable_cool = 16'h0050;
    wire logic [15:0] remote_set_point          = 16'h005A;
    logic             set_point_changed         = 1'b0;
    wire logic        loop_burnout_alarm        = flag;
    wire logic        change_rate_alarm         = flag;
    wire logic        heater_fault_alarm        = flag;
    pae_alarm #(.TICK_CYCLES(32'h0000_000A)) pae_alarm_i (.*);
    pae_front_end pae_front_end_i (.pclk(pclk), .process_value(process_value),
        .set_point(set_point), .hysteresis(hysteresis), .flag(flag));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ====================
    // Bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %0t register got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_alarm(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %0t alarm got %b expected %b", $time, g, e);
        end
    endtask
    task automatic step(input logic [4:0] t, input int p, input int s, input int h,
                        input logic e);
        pae_front_end_i.set(p[15:0], s[15:0], h[15:0], 1'b1);
        if (t !== cur)
            apb(1'b1, 12'h000, {27'h0, t});
        cur = t;
        repeat (4) @(posedge pclk);
        cmp_alarm(alarm_out, e);
    endtask
    task automatic end_of_test();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // Tests
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, num_checks, cur} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pae_front_end_i.set(16'h0000, 16'h0000, 16'h0000, 1'b1);
        repeat (4) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        cmp_reg(rd, 32'h0000_0000);
        apb(1'b1, 12'h018, 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0);
        cmp_reg(rd, 32'h0000_0002);
        cur = 5'h2;
        apb(1'b1, 12'h004, 32'h0000_0064);
        apb(1'b1, 12'h008, 32'h0000_000A);
        apb(1'b1, 12'h00C, 32'h0000_000A);
        step(5'd0, 500, 0, 0, 1'b0);
        step(5'd2, 100, 0, 0, 1'b1);
        step(5'd2, 99, 0, 0, 1'b0);
        step(5'd3, -100, 0, 0, 1'b1);
        step(5'd3, -99, 0, 0, 1'b0);
        step(5'd1, 10, 0, 0, 1'b1);
        step(5'd1, 5, 0, 0, 1'b0);
        step(5'd1, -10, 0, 0, 1'b1);
        step(5'd4, 10, 0, 0, 1'b1);
        step(5'd4, 20, 0, 0, 1'b0);
        step(5'd5, 0, 0, 0, 1'b0);
        step(5'd5, 200, 0, 0, 1'b1);
        step(5'd5, 200, 0, 15, 1'b0);
        step(5'd6, 200, 0, 0, 1'b0);
        step(5'd6, 0, 0, 0, 1'b0);
        step(5'd6, 200, 0, 0, 1'b1);
        @(posedge pclk) set_point_changed <= 1'b1;
        @(posedge pclk) set_point_changed <= 1'b0;
        repeat (4) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b0);
        step(5'd8, 101, 0, 0, 1'b1);
        step(5'd8, 100, 0, 0, 1'b0);
        step(5'd9, 99, 0, 0, 1'b1);
        step(5'd14, 0, 101, 0, 1'b1);
        step(5'd14, 0, 100, 0, 1'b0);
        step(5'd15, 0, 99, 0, 1'b1);
        step(5'd16, 0, 0, 0, 1'b1);
        step(5'd17, 0, 0, 0, 1'b0);
        step(5'd18, 0, 0, 0, 1'b0);
        step(5'd19, 0, 0, 0, 1'b1);
        step(5'd12, 0, 0, 0, 1'b1);
        pae_front_end_i.set(16'h0000, 16'h0000, 16'h0000, 1'b0);
        repeat (4) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b0);
        step(5'd13, 0, 0, 0, 1'b1);
        pae_front_end_i.set(16'h0000, 16'h0000, 16'h0000, 1'b0);
        repeat (4) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b0);
        apb(1'b1, 12'h018, 32'h0000_0003);
        step(5'd17, 0, 0, 0, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_0019);
        apb(1'b0, 12'h000, 32'h0);
        cmp_reg(rd, 32'h0000_0011);
        apb(1'b1, 12'h010, 32'h0000_03E8);
        apb(1'b0, 12'h010, 32'h0);
        cmp_reg(rd, 32'h0000_03E7);
        apb(1'b0, 12'h020, 32'h0);
        cmp_reg({31'h0, err}, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0002);
        step(5'd8, 0, 0, 0, 1'b0);
        pae_front_end_i.set(16'h00C8, 16'h0000, 16'h0000, 1'b1);
        repeat (5) @(posedge pclk);
        pae_front_end_i.set(16'h0000, 16'h0000, 16'h0000, 1'b1);
        repeat (40) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b0);
        pae_front_end_i.set(16'h00C8, 16'h0000, 16'h0000, 1'b1);
        repeat (5) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b0);
        repeat (40) @(posedge pclk);
        cmp_alarm(alarm_out, 1'b1);
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
